//--- dv/motion_readout_tb.sv
// self-checking bench of the motion readout register set
// assumes: serial_host_model provides the register transfers
`timescale 1ns/1ns
`default_nettype none
`include "motion_readout_regs.svh"
module motion_readout_tb;
   import motion_readout_pkg::*;
   localparam int         PIX = 8;     // short frame keeps grab tests quick
   localparam logic [2:0] PID = 3'h2;  // arbitrary identity value
   logic       ref_clk_in, reset_n_in, sck_in, sdio_in, sdio_out, sdio_oe_out, awake_out;
   logic       motion_valid_in, feature_valid_in, pixel_valid_in, frame_start_in, forced_awake_out;
   logic [7:0] motion_dx_in, motion_dy_in, rd;
   logic [8:0] feature_count_in;
   logic [5:0] pixel_level_in;
   int         errors = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   motion_readout #(.PART_ID(PID), .SLEEP_FRAMES(4), .PIXELS(PIX)) motion_readout_i (.ref_clk_in, .reset_n_in,
      .sck_in, .sdio_in, .sdio_out, .sdio_oe_out, .motion_valid_in, .motion_dx_in, .motion_dy_in,
      .feature_valid_in, .feature_count_in, .pixel_valid_in, .frame_start_in, .pixel_level_in,
      .awake_out, .forced_awake_out);
   serial_host_model serial_host_model_i (.dev_oe_in(sdio_oe_out), .dev_d_in(sdio_out), .sck_out(sck_in),
      .sdio_out(sdio_in));
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdreg(input logic [6:0] a, input logic [7:0] e, input string n);
      serial_host_model_i.xfer({1'b0, a}, 8'h00, rd);
      chk(n, rd, e);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      serial_host_model_i.xfer({1'b1, a}, d, rd);
   endtask
   // one sensor frame, pixel p has level 7*p
   task automatic frame;
      for (int p = 1; p <= PIX; p++) begin
         @(negedge ref_clk_in) {pixel_valid_in, frame_start_in, pixel_level_in} = {1'b1, p == 1, 6'(p * 7)};
         @(negedge ref_clk_in) pixel_valid_in = 1'b0;
      end
   endtask
   task automatic mot(input logic [7:0] x, input logic [7:0] y);
      @(negedge ref_clk_in) {motion_valid_in, motion_dx_in, motion_dy_in} = {1'b1, x, y};
      @(negedge ref_clk_in) motion_valid_in = 1'b0;
   endtask
   task automatic summarize;
      if (errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      {reset_n_in, motion_valid_in, feature_valid_in, pixel_valid_in, frame_start_in} = '0;
      {motion_dx_in, motion_dy_in, feature_count_in, pixel_level_in} = '0;
      repeat (2) @(negedge ref_clk_in);
      reset_n_in = 1'b1;
      repeat (5) @(negedge ref_clk_in);
      rdreg(`MR_ADDR_STATUS, {PID, 5'h01}, "status");
      rdreg(`MR_ADDR_DARK, 8'h3F, "dark_reset");
      rdreg(`MR_ADDR_INTENSITY, 8'h00, "sum_reset");
      // accumulate past both ends of the signed range
      mot(8'h64, 8'h9C);
      mot(8'h64, 8'h9C);
      rdreg(`MR_ADDR_HORIZ, 8'h7F, "horiz_sat");
      rdreg(`MR_ADDR_VERT, 8'h80, "vert_sat");
      rdreg(`MR_ADDR_HORIZ, 8'h00, "horiz_clr");
      mot(8'hFE, 8'h01);
      mot(8'h00, 8'h02);
      rdreg(`MR_ADDR_HORIZ, 8'hFE, "horiz_neg");
      rdreg(`MR_ADDR_VERT, 8'h03, "vert_acc");
      @(negedge ref_clk_in) {feature_valid_in, feature_count_in} = {1'b1, 9'h1A7};
      @(negedge ref_clk_in) feature_valid_in = 1'b0;
      rdreg(`MR_ADDR_FEATURE, 8'hD3, "feature");
      frame();
      rdreg(`MR_ADDR_BRIGHT, 8'h38, "bright");
      rdreg(`MR_ADDR_DARK, 8'h07, "dark");
      rdreg(`MR_ADDR_INTENSITY, 8'h01, "sum");
      // grab every pixel once and the wrap back to pixel one, forced awake as a host must
      wr(`MR_ADDR_CONFIG, 8'h01);
      wr(`MR_ADDR_GRAB, 8'hA5);
      for (int i = 0; i <= PIX; i++) begin
         frame();
         rdreg(`MR_ADDR_GRAB, {i % PIX == 0, 1'b1, 6'((i % PIX + 1) * 7)}, "grab");
      end
      serial_host_model_i.xfer({1'b0, `MR_ADDR_GRAB}, 8'h00, rd);
      chk("grab_nodata", rd & 8'hC0, 8'h00);
      // release forced awake; four still frames then put the sensor to sleep
      wr(`MR_ADDR_CONFIG, 8'h00);
      repeat (4) frame();
      rdreg(`MR_ADDR_GRAB, {2'b01, 6'h0E}, "grab_held");
      rdreg(`MR_ADDR_STATUS, {PID, 5'h00}, "status_asleep");
      wr(`MR_ADDR_CONFIG, 8'h01);
      chk("forced_wake", {6'h00, forced_awake_out, awake_out}, 8'h03);
      rdreg(`MR_ADDR_CONFIG, 8'h01, "config_read");
      summarize();
   end
endmodule // motion_readout_tb
`default_nettype wire

//--- dv/serial_host_model.sv
// host microcontroller model on the two-wire register port
// assumes: sck idles high, 125 ns bit period, device resolves its drive here
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
   input  wire logic dev_oe_in,  // device drives the data wire
   input  wire logic dev_d_in,   // device data value
   output logic      sck_out,    // serial clock, idle high
   output logic      sdio_out    // resolved data wire level
);
   logic en_r = 1'b1;  // host drives the data wire
   logic v_r  = 1'b1;  // host data value
   // no pull-up: a released wire shows the inverse of the last value
   assign sdio_out = dev_oe_in ? dev_d_in : (en_r ? v_r : ~v_r);
   initial sck_out = 1'b1;
   // address byte then data byte, msb first, data changed while sck low
   task automatic xfer(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {a, wd};
      #1 en_r = 1'b1;  // offset keeps sck edges clear of the ref clock edges
      for (int i = 15; i >= 0; i--) begin
         #62 sck_out = 1'b0;
         if (i == 7) en_r = a[7];  // read: let go of the wire
         if (en_r) v_r = sh[i];
         #63 sck_out = 1'b1;
         if (i < 8) rd[i] = sdio_out;  // sampled on the rising edge
      end
      #249 en_r = 1'b1;  // device has dropped its enable; 2250 ns in all keeps the phase
   endtask
endmodule // serial_host_model
`default_nettype wire

//--- hdl/frame_stats.sv
// per-frame pixel statistics: brightest, darkest, scaled sum, pixel numbering
// assumes: pixels arrive on ref_clk_in, frame_start_in marks pixel 1
`timescale 1ns/1ns
`default_nettype none
`include "motion_readout_regs.svh"
module frame_stats #(
   parameter int PIXELS = `MR_PIXELS_PER_FRAME  // pixels in one frame
) (
   input  wire logic       ref_clk_in,       // system clock
   input  wire logic       reset_n_in,       // async reset, active low
   input  wire logic       pixel_valid_in,   // one pixel this cycle
   input  wire logic       frame_start_in,   // this pixel is number 1
   input  wire logic [5:0] pixel_level_in,   // pixel brightness
   output logic            pixel_valid_out,  // registered pixel strobe
   output logic            frame_start_out,  // registered frame start
   output logic [5:0]      pixel_level_out,  // registered pixel level
   output logic [8:0]      pixel_index_out,  // number of registered pixel
   output logic            frame_done_out,   // statistics just latched
   output logic [5:0]      bright_out,       // brightest of last frame
   output logic [5:0]      dark_out,         // darkest of last frame
   output logic [7:0]      intensity_out     // sum of last frame / 128
);
   logic [5:0]  run_max_r;   // running maximum
   logic [5:0]  run_min_r;   // running minimum
   logic [14:0] run_sum_r;   // running sum, 324 x 63 fits 15 bits
   logic [8:0]  idx_nxt;     // number of the incoming pixel
   logic [5:0]  max_nxt;     // maximum including incoming pixel
   logic [5:0]  min_nxt;     // minimum including incoming pixel
   logic [14:0] sum_nxt;     // sum including incoming pixel

   // fold the incoming pixel into the running values
   always_comb begin
      idx_nxt = frame_start_in ? 9'h001 : pixel_index_out + 9'h001;
      max_nxt = (frame_start_in || pixel_level_in > run_max_r) ? pixel_level_in : run_max_r;
      min_nxt = (frame_start_in || pixel_level_in < run_min_r) ? pixel_level_in : run_min_r;
      sum_nxt = (frame_start_in ? 15'h0000 : run_sum_r) + {9'h000, pixel_level_in};
   end

   // running accumulators and the registered pixel stream
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         run_max_r       <= `MR_RST_BRIGHT;
         run_min_r       <= `MR_RST_DARK;
         run_sum_r       <= 15'h0000;
         pixel_valid_out <= 1'b0;
         frame_start_out <= 1'b0;
         pixel_level_out <= 6'h00;
         pixel_index_out <= 9'h000;
      end else begin
         pixel_valid_out <= pixel_valid_in;
         frame_start_out <= pixel_valid_in & frame_start_in;
         if (pixel_valid_in) begin
            run_max_r       <= max_nxt;
            run_min_r       <= min_nxt;
            run_sum_r       <= sum_nxt;
            pixel_level_out <= pixel_level_in;
            pixel_index_out <= idx_nxt;
         end
      end
   end

   // results are latched only when the last pixel of a frame is seen
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         frame_done_out <= 1'b0;
         bright_out     <= `MR_RST_BRIGHT;
         dark_out       <= `MR_RST_DARK;
         intensity_out  <= `MR_RST_INTENSITY;
      end else begin
         frame_done_out <= pixel_valid_in && idx_nxt == 9'(PIXELS);
         if (pixel_valid_in && idx_nxt == 9'(PIXELS)) begin
            bright_out    <= max_nxt;
            dark_out      <= min_nxt;
            intensity_out <= sum_nxt[14:`MR_SUM_SHIFT];
         end
      end
   end
endmodule // frame_stats
`default_nettype wire

//--- hdl/motion_readout.sv
// read-side register set of an optical motion sensor behind a two-wire port
// assumes: host drives sck_in, sdio is shared; sensor core on ref_clk_in
//
// Notes on behaviour
// - status upper bits carry fixed part identity
// - status bit 0 reads 1 awake, 0 asleep
// - motion counts accumulate since previous read
// - motion counts are 8-bit two's complement
// - reading a motion count clears it
// - feature count register holds upper 8 bits
// - feature count capped at 255, per frame
// - brightest pixel of frame, 6 bits
// - darkest pixel of frame, reset 0x3F
// - intensity register is frame sum over 128
// - grab read: start flag, valid flag, level
// - grab write restarts at pixel one
// - each grab read that delivers a valid pixel advances the pixel
// - after pixel 324 wrap to pixel one
// - at most one grabbed pixel per frame
// - grab access arms; captured pixel is held
// - sleep after 1500 still frames unless forced
// - all access goes through the serial port
`timescale 1ns/1ns
`default_nettype none
`include "motion_readout_regs.svh"
module motion_readout
   import motion_readout_pkg::*;
#(
   parameter logic [2:0] PART_ID      = 3'h5,               // arbitrary identity value
   parameter int         SLEEP_FRAMES = `MR_SLEEP_FRAMES,   // still frames before sleep
   parameter int         PIXELS       = `MR_PIXELS_PER_FRAME // pixels per frame
) (
   input  wire logic       ref_clk_in,        // system clock, 100 MHz
   input  wire logic       reset_n_in,        // async reset, active low
   input  wire logic       sck_in,            // serial clock from host
   input  wire logic       sdio_in,           // serial data pin level
   output logic            sdio_out,          // serial data driven value
   output logic            sdio_oe_out,       // high while driving sdio
   input  wire logic       motion_valid_in,   // one motion sample
   input  wire logic [7:0] motion_dx_in,      // horizontal step, signed
   input  wire logic [7:0] motion_dy_in,      // vertical step, signed
   input  wire logic       feature_valid_in,  // feature count ready
   input  wire logic [8:0] feature_count_in,  // features in frame
   input  wire logic       pixel_valid_in,    // one pixel this cycle
   input  wire logic       frame_start_in,    // pixel is number 1
   input  wire logic [5:0] pixel_level_in,    // pixel brightness
   output logic            awake_out,         // sensor awake state
   output logic            forced_awake_out   // forced awake config bit
);
   // pin synchronisers and edge detection
   logic       sck_s1_r, sck_s2_r, sck_d3_r;  // serial clock chain
   logic       sdio_s1_r, sdio_s2_r;          // serial data chain
   logic       sck_rise, sck_fall;            // host clock edges

   // serial port engine
   port_state_type state_r;                   // current phase
   logic [2:0] bit_cnt_r;                     // bit within byte
   logic [6:0] shift_in_r;                    // incoming bits
   logic [6:0] addr_r;                        // latched address
   logic [7:0] shift_out_r;                   // outgoing bits
   logic [7:0] rd_value;                      // addressed register value
   logic       rd_pulse;                      // read taken this cycle
   logic       wr_pulse;                      // write taken this cycle
   logic [6:0] cur_addr;                      // address just completed
   logic [7:0] wr_data;                       // write byte just completed

   // register contents
   logic       forced_awake_r;                // config bit 0
   logic       awake_r;                       // awake state
   logic [$clog2(SLEEP_FRAMES+1)-1:0] idle_r; // still frames counted
   logic [7:0] vert_r, horiz_r;               // motion counts
   logic [7:0] feature_r;                     // feature count / 2
   logic [7:0] status_value;                  // status read value

   // frame statistics stream
   logic       st_valid, st_fs, st_done;      // stream strobes
   logic [5:0] st_level, bright, dark;        // levels
   logic [8:0] st_index;                      // pixel number
   logic [7:0] intensity;                     // sum / 128

   // frame grabber
   logic [8:0] grab_ptr_r;                    // pixel to fetch next
   logic [5:0] grab_level_r;                  // held pixel
   logic       grab_valid_r;                  // held pixel is fresh
   logic       grab_armed_r;                  // waiting for a frame start
   logic       grab_active_r;                 // frame running, looking
   logic       grab_cap;                      // capture this cycle
   logic       grab_rd, grab_wr;              // grab port accesses
   logic       cap_seen_r;                    // helper: capture in frame

   // saturating signed add, so fast motion pins at the limit
   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {a[7], a} + {b[7], b};
      if (s[8] != s[7]) begin
         return s[8] ? `MR_MOTION_MIN : `MR_MOTION_MAX;
      end
      return s[7:0];
   endfunction

   frame_stats #(
      .PIXELS (PIXELS)
   ) u_stats (
      .ref_clk_in      (ref_clk_in),
      .reset_n_in      (reset_n_in),
      .pixel_valid_in  (pixel_valid_in),
      .frame_start_in  (frame_start_in),
      .pixel_level_in  (pixel_level_in),
      .pixel_valid_out (st_valid),
      .frame_start_out (st_fs),
      .pixel_level_out (st_level),
      .pixel_index_out (st_index),
      .frame_done_out  (st_done),
      .bright_out      (bright),
      .dark_out        (dark),
      .intensity_out   (intensity)
   );

   // two flops on each pin before anything looks at it
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sck_s1_r  <= 1'b1;
         sck_s2_r  <= 1'b1;
         sck_d3_r  <= 1'b1;
         sdio_s1_r <= 1'b1;
         sdio_s2_r <= 1'b1;
      end else begin
         sck_s1_r  <= sck_in;
         sck_s2_r  <= sck_s1_r;
         sck_d3_r  <= sck_s2_r;
         sdio_s1_r <= sdio_in;
         sdio_s2_r <= sdio_s1_r;
      end
   end

   assign sck_rise = sck_s2_r & ~sck_d3_r;
   assign sck_fall = ~sck_s2_r & sck_d3_r;

   // byte completion decode; the eighth rising edge closes a byte
   assign cur_addr = {shift_in_r[5:0], sdio_s2_r};
   assign wr_data  = {shift_in_r, sdio_s2_r};
   assign rd_pulse = sck_rise && state_r == PORT_ADDR && bit_cnt_r == 3'h7 && !shift_in_r[6];
   assign wr_pulse = sck_rise && state_r == PORT_WDATA && bit_cnt_r == 3'h7;
   assign grab_rd  = rd_pulse && cur_addr == `MR_ADDR_GRAB;
   assign grab_wr  = wr_pulse && addr_r == `MR_ADDR_GRAB;

   // status: identity on top, reserved zero, awake in bit 0
   assign status_value = {PART_ID, 4'h0, awake_r};

   // read mux; unmapped addresses read zero
   always_comb begin
      case (cur_addr)
         `MR_ADDR_CONFIG:    rd_value = {7'h00, forced_awake_r};
         `MR_ADDR_STATUS:    rd_value = status_value;
         `MR_ADDR_VERT:      rd_value = vert_r;
         `MR_ADDR_HORIZ:     rd_value = horiz_r;
         `MR_ADDR_FEATURE:   rd_value = feature_r;
         `MR_ADDR_BRIGHT:    rd_value = {2'b00, bright};
         `MR_ADDR_DARK:      rd_value = {2'b00, dark};
         `MR_ADDR_INTENSITY: rd_value = intensity;
         `MR_ADDR_GRAB:      rd_value = {grab_ptr_r == 9'h001, grab_valid_r, grab_level_r};
         default:            rd_value = 8'h00;
      endcase
   end

   // serial engine: address byte, then a data byte in or out
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r     <= PORT_ADDR;
         bit_cnt_r   <= 3'h0;
         shift_in_r  <= 7'h00;
         addr_r      <= 7'h00;
         shift_out_r <= 8'h00;
         sdio_oe_out <= 1'b0;
      end else begin
         case (state_r)
            PORT_ADDR: begin
               if (sck_rise) begin
                  bit_cnt_r  <= bit_cnt_r + 3'h1;
                  shift_in_r <= wr_data[6:0];
                  if (bit_cnt_r == 3'h7) begin
                     addr_r <= cur_addr;
                     if (shift_in_r[6]) begin
                        state_r <= PORT_WDATA;   // top address bit set: write
                     end else begin
                        // value is frozen here, so later motion cannot tear it
                        state_r     <= PORT_RDATA;
                        shift_out_r <= rd_value;
                        sdio_oe_out <= 1'b1;
                     end
                  end
               end
            end
            PORT_WDATA: begin
               if (sck_rise) begin
                  bit_cnt_r  <= bit_cnt_r + 3'h1;
                  shift_in_r <= wr_data[6:0];
                  if (bit_cnt_r == 3'h7) begin
                     state_r <= PORT_ADDR;
                  end
               end
            end
            PORT_RDATA: begin
               if (sck_fall && bit_cnt_r != 3'h0) begin
                  shift_out_r <= {shift_out_r[6:0], 1'b0};   // first fall keeps bit 7 up for the host
               end
               if (sck_rise) begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == 3'h7) begin
                     state_r     <= PORT_ADDR;
                     sdio_oe_out <= 1'b0;    // host sampled the last bit
                  end
               end
            end
            default: begin
               state_r     <= PORT_ADDR;
               sdio_oe_out <= 1'b0;
            end
         endcase
      end
   end

   assign sdio_out = shift_out_r[7];

   // configuration: only the forced awake bit is kept
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         forced_awake_r <= `MR_RST_CONFIG == 8'h00 ? 1'b0 : 1'b1;
      end else if (wr_pulse && addr_r == `MR_ADDR_CONFIG) begin
         forced_awake_r <= wr_data[`MR_CFG_FORCED_AWAKE];
      end
   end

   assign forced_awake_out = forced_awake_r;
   assign awake_out        = awake_r;

   // sleep after a second of still frames unless forced awake
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         awake_r <= 1'b1;
         idle_r  <= '0;
      end else if (forced_awake_r || (motion_valid_in && (motion_dx_in != 8'h00 || motion_dy_in != 8'h00))) begin
         awake_r <= 1'b1;
         idle_r  <= '0;
      end else if (st_done && awake_r) begin
         if (idle_r == $bits(idle_r)'(SLEEP_FRAMES - 1)) begin
            awake_r <= 1'b0;
            idle_r  <= '0;
         end else begin
            idle_r <= idle_r + 1'b1;
         end
      end
   end

   // motion counts: a read clears, new motion in the same cycle survives
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         vert_r  <= `MR_RST_MOTION;
         horiz_r <= `MR_RST_MOTION;
      end else begin
         if (rd_pulse && cur_addr == `MR_ADDR_VERT) begin
            vert_r <= motion_valid_in ? motion_dy_in : 8'h00;
         end else if (motion_valid_in) begin
            vert_r <= sat_add(vert_r, motion_dy_in);
         end
         if (rd_pulse && cur_addr == `MR_ADDR_HORIZ) begin
            horiz_r <= motion_valid_in ? motion_dx_in : 8'h00;
         end else if (motion_valid_in) begin
            horiz_r <= sat_add(horiz_r, motion_dx_in);
         end
      end
   end

   // feature count: upper 8 of 9 bits, so never above 255
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         feature_r <= `MR_RST_FEATURE;
      end else if (feature_valid_in) begin
         feature_r <= feature_count_in[8:1];
      end
   end

   // a capture needs the wanted pixel within a frame that began after arming
   assign grab_cap = st_valid && st_index == grab_ptr_r && (grab_active_r || (grab_armed_r && st_fs));

   // frame grabber: arm on access, capture one pixel, hold until read
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         grab_ptr_r    <= 9'h001;
         grab_level_r  <= 6'h00;
         grab_valid_r  <= 1'b0;
         grab_armed_r  <= 1'b0;
         grab_active_r <= 1'b0;
      end else if (grab_wr) begin
         grab_ptr_r    <= 9'h001;
         grab_valid_r  <= 1'b0;
         grab_armed_r  <= 1'b1;
         grab_active_r <= 1'b0;
      end else if (grab_rd) begin
         if (grab_valid_r) begin
            // only a read that delivered a pixel moves the pointer
            grab_ptr_r <= (grab_ptr_r == 9'(PIXELS)) ? 9'h001 : grab_ptr_r + 9'h001;
         end
         grab_valid_r  <= grab_cap;        // set wins: a pixel landing beside an empty read is kept
         grab_level_r  <= grab_cap ? st_level : grab_level_r;
         grab_armed_r  <= !grab_cap;
         grab_active_r <= 1'b0;
      end else begin
         if (st_valid && st_fs) begin
            grab_armed_r <= 1'b0;
         end
         grab_active_r <= (grab_active_r || (grab_armed_r && st_valid && st_fs)) && !grab_cap;
         if (grab_cap) begin
            grab_level_r <= st_level;      // held however long the host waits
            grab_valid_r <= 1'b1;
         end
      end
   end

   // helper for checking: was a pixel captured since the last frame start
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cap_seen_r <= 1'b0;
      end else if (st_valid && st_fs) begin
         cap_seen_r <= grab_cap;
      end else if (grab_cap) begin
         cap_seen_r <= 1'b1;
      end
   end
   // checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   sequence s_grab_write;
      grab_wr;
   endsequence
   sequence s_pointer_home;
      grab_ptr_r == 9'h001 && !grab_valid_r && grab_armed_r;
   endsequence
   a_status_identity: assert property (rd_pulse && cur_addr == `MR_ADDR_STATUS
         |=> shift_out_r[7:1] == {PART_ID, 4'h0})
      else $error("status identity or reserved bits wrong");
   a_status_awake: assert property (forced_awake_r |=> status_value[0])
      else $error("status reads asleep while forced awake");
   a_vert_cleared: assert property (rd_pulse && cur_addr == `MR_ADDR_VERT && !motion_valid_in |=> vert_r == 8'h00)
      else $error("vertical count not cleared by read");
   a_motion_saturate: assert property (motion_valid_in && !rd_pulse && !horiz_r[7]
         && !motion_dx_in[7] |=> !horiz_r[7])
      else $error("horizontal count wrapped past maximum");
   a_level_range: assert property (st_done |-> dark <= st_level && st_level <= bright)
      else $error("frame levels do not bracket the last pixel");
   a_grab_restart: assert property (s_grab_write |=> s_pointer_home)
      else $error("grab write did not restart at pixel one");
   a_grab_wrap: assert property (grab_rd && grab_valid_r && grab_ptr_r == 9'(PIXELS) |=> grab_ptr_r == 9'h001)
      else $error("grab pointer did not wrap after last pixel");
   a_grab_once: assert property (grab_cap && !(st_valid && st_fs) |-> !cap_seen_r)
      else $error("second grab capture within one frame");
   a_grab_held: assert property (grab_valid_r && !grab_rd && !grab_wr |=> grab_valid_r && $stable(grab_level_r))
      else $error("held grab pixel changed before read");
   a_sleep_needs_idle: assert property ($fell(awake_r) |-> !forced_awake_r && $past(st_done))
      else $error("sleep entered without a still frame count");
endmodule // motion_readout
`default_nettype wire

//--- hdl/motion_readout_pkg.sv
// types shared by the motion readout register set
// assumes: the register header sits on the include path
package motion_readout_pkg;
   `include "motion_readout_regs.svh"

   // serial port phases
   typedef enum logic [1:0] {
      PORT_ADDR  = 2'b00,   // shifting in the address byte
      PORT_WDATA = 2'b01,   // shifting in write data
      PORT_RDATA = 2'b10    // driving read data out
   } port_state_type;
endpackage

//--- hdl/motion_readout_regs.svh
// register map, reset values and counts of the motion readout register set
// assumes: included by bare name from the package and the design modules
`ifndef MOTION_READOUT_REGS_SVH
`define MOTION_READOUT_REGS_SVH

// register addresses on the serial port (7-bit address field)
`define MR_ADDR_CONFIG      7'h00
`define MR_ADDR_STATUS      7'h01
`define MR_ADDR_VERT        7'h02
`define MR_ADDR_HORIZ       7'h03
`define MR_ADDR_FEATURE     7'h04
`define MR_ADDR_BRIGHT      7'h05
`define MR_ADDR_DARK        7'h06
`define MR_ADDR_INTENSITY   7'h07
`define MR_ADDR_GRAB        7'h08

// reset values
`define MR_RST_CONFIG       8'h00
`define MR_RST_MOTION       8'h00
`define MR_RST_FEATURE      8'h00
`define MR_RST_BRIGHT       6'h00
`define MR_RST_DARK         6'h3F
`define MR_RST_INTENSITY    8'h00

// field positions
`define MR_CFG_FORCED_AWAKE 0
`define MR_CMD_WRITE_BIT    7

// saturation limits of the signed motion counts
`define MR_MOTION_MAX       8'h7F
`define MR_MOTION_MIN       8'h80

// frame geometry and timing
`define MR_PIXELS_PER_FRAME 324
`define MR_FRAME_RATE_HZ    1500
`define MR_SLEEP_TIME_S     1
`define MR_SLEEP_FRAMES     (`MR_FRAME_RATE_HZ * `MR_SLEEP_TIME_S)
`define MR_SUM_SHIFT        7

`endif
